/* src/ipvb_defs.svh */
// Behaviour
// - a two-bit level code per source: 00 off, 01/10/11 levels 0/1/2.
// - after reset every level field reads zero: all sources disabled.
// - serial register bits 7-6 bus-status level, bits 5-4 transmit.
// - serial register bits 3-2 receive level, bits 1-0 general call.
// - timer register (index 5): timer 1 in bits 15-14, timer 0 in 13-12.
// - timer register: second comparator bits 11-10, first bits 9-8.
// - pwm register (index 6): fault level bits 11-10, reload bits 9-8.
// - pwm register: zero-crossing bits 7-6, second converter bits 5-4.
// - pwm register: first converter bits 3-2, interval timer 2 bits 1-0.
// - vector base (index 7) bits 13-0 are the top 14 of 21 address bits.
// - the winner gives the low 7 address bits, appended below the base.
// - vector base resets to 0x0080 (address 0x004000), small variant 0.
// - bits 5-0 of a fast match register name the source served fast.
// - a fast interrupt beats other level-2 sources; fast 0 beats fast 1.
`ifndef IPVB_DEFS_SVH
`define IPVB_DEFS_SVH
// register indices; byte address is four times the index
`define IPVB_IDX_SERIAL 6'h04
`define IPVB_IDX_TIMER 6'h05
`define IPVB_IDX_PWM 6'h06
`define IPVB_IDX_VBASE 6'h07
`define IPVB_IDX_FAST0 6'h08
`define IPVB_IDX_FAST1 6'h0B
`define IPVB_IDX_STATUS 6'h10
`define IPVB_IDX_MASK 6'h11
`define IPVB_IDX_VECTOR 6'h12
// implemented bits of each register
`define IPVB_SERIAL_BITS 16'h00FF
`define IPVB_TIMER_BITS 16'hFF00
`define IPVB_PWM_BITS 16'h0FFF
`define IPVB_VBASE_BITS 16'h3FFF
`define IPVB_FAST_BITS 16'h003F
// reset values
`define IPVB_LEVEL_RST 16'h0000
`define IPVB_VBASE_RST 16'h0080
`define IPVB_VBASE_RST_SMALL 16'h0000
`define IPVB_FAST_RST 16'h0000
// vector number of source 0; source i uses this plus i
`define IPVB_VEC_FIRST 7'h20
// ranks used in arbitration
`define IPVB_RANK_FAST1 3'h4
`define IPVB_RANK_FAST0 3'h5
// interrupt status bits
`define IPVB_EV_RAISE 0
`define IPVB_EV_CHANGE 1
`endif

/* src/ipvb_pkg.sv */
package ipvb_pkg;
  // two-bit level codes of each source field
  typedef enum logic [1:0]
  {
    IPVB_LVL_OFF = 2'b00,
    IPVB_LVL_0 = 2'b01,
    IPVB_LVL_1 = 2'b10,
    IPVB_LVL_2 = 2'b11
  } ipvb_level_type;
  typedef logic [2:0] ipvb_rank_type;
  typedef logic [6:0] ipvb_vecnum_type;
endpackage : ipvb_pkg

/* src/ipvb_top.sv */
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`include "ipvb_defs.svh"
module ipvb_top
#(
  parameter int NSRC = 14,
  parameter bit SMALL_VARIANT = 1'b0
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // peripheral requests, same clock
  input wire logic [NSRC-1:0] irq_src_in,
  // core side
  output logic core_req_out,
  output logic [1:0] core_level_out,
  output logic [20:0] vector_address_bus_out,
  // block interrupt
  output logic irq_out
);

  logic [15:0] serial_q;
  logic [15:0] timer_q;
  logic [15:0] pwm_q;
  logic [15:0] vbase_q;
  logic [15:0] fast0_q;
  logic [15:0] fast1_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic [1:0] events;
  logic ack_q;
  logic [31:0] rdat_q;
  logic req_q;
  logic [1:0] level_q;
  logic [20:0] vab_q;
  logic irq_q;
  logic [5:0] idx;
  logic access;
  logic wr;
  logic [15:0] lane_mask;
  logic [15:0] rd_word;
  logic [2*NSRC-1:0] levels;
  ipvb_pkg::ipvb_rank_type rank [NSRC];
  ipvb_pkg::ipvb_vecnum_type vecnum [NSRC];
  ipvb_pkg::ipvb_rank_type best_rank;
  ipvb_pkg::ipvb_vecnum_type best_vec;
  logic [1:0] best_level;
  logic any;

  localparam logic [15:0] VBASE_RESET =
    SMALL_VARIANT ? `IPVB_VBASE_RST_SMALL : `IPVB_VBASE_RST;

  // bus decode; only the two low byte lanes carry register data
  assign idx = wb_adr_in[7:2];
  assign access = wb_cyc_in & wb_stb_in;
  assign wr = access & wb_we_in & ack_q;
  assign lane_mask = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ack_q <= 1'b0;
    else
      ack_q <= access & ~ack_q;
  end

  // level registers; reserved bits are not stored so they read zero
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      serial_q <= `IPVB_LEVEL_RST;
      timer_q <= `IPVB_LEVEL_RST;
      pwm_q <= `IPVB_LEVEL_RST;
    end
    else if (wr)
    begin
      if (idx == `IPVB_IDX_SERIAL)
        serial_q <= (serial_q & ~lane_mask) |
          (wb_dat_in[15:0] & lane_mask & `IPVB_SERIAL_BITS);
      if (idx == `IPVB_IDX_TIMER)
        timer_q <= (timer_q & ~lane_mask) |
          (wb_dat_in[15:0] & lane_mask & `IPVB_TIMER_BITS);
      if (idx == `IPVB_IDX_PWM)
        pwm_q <= (pwm_q & ~lane_mask) |
          (wb_dat_in[15:0] & lane_mask & `IPVB_PWM_BITS);
    end
  end

  // vector base and fast match registers
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      vbase_q <= VBASE_RESET;
      fast0_q <= `IPVB_FAST_RST;
      fast1_q <= `IPVB_FAST_RST;
    end
    else if (wr)
    begin
      if (idx == `IPVB_IDX_VBASE)
        vbase_q <= (vbase_q & ~lane_mask) |
          (wb_dat_in[15:0] & lane_mask & `IPVB_VBASE_BITS);
      if (idx == `IPVB_IDX_FAST0)
        fast0_q <= (fast0_q & ~lane_mask) |
          (wb_dat_in[15:0] & lane_mask & `IPVB_FAST_BITS);
      if (idx == `IPVB_IDX_FAST1)
        fast1_q <= (fast1_q & ~lane_mask) |
          (wb_dat_in[15:0] & lane_mask & `IPVB_FAST_BITS);
    end
  end

  // read mux; unmapped indices answer zero
  always_comb
  begin
    case (idx)
      `IPVB_IDX_SERIAL: rd_word = serial_q;
      `IPVB_IDX_TIMER: rd_word = timer_q;
      `IPVB_IDX_PWM: rd_word = pwm_q;
      `IPVB_IDX_VBASE: rd_word = vbase_q;
      `IPVB_IDX_FAST0: rd_word = fast0_q;
      `IPVB_IDX_FAST1: rd_word = fast1_q;
      `IPVB_IDX_STATUS: rd_word = {14'h0000, status_q};
      `IPVB_IDX_MASK: rd_word = {14'h0000, mask_q};
      `IPVB_IDX_VECTOR: rd_word = {req_q, level_q, 6'h00, vab_q[6:0]};
      default: rd_word = 16'h0000;
    endcase
  end

  // read data captured with the ack
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdat_q <= 32'h0000_0000;
    else if (access & ~ack_q)
      rdat_q <= {16'h0000, rd_word};
    else
      rdat_q <= 32'h0000_0000;
  end

  // one flat field vector: source i lives in levels[2i+1:2i]
  assign levels = {pwm_q[11:0], timer_q[15:8], serial_q[7:0]};

  // per-source rank: 0 disabled, 1..3 the coded level, 4..5 fast
  generate
    for (genvar i = 0; i < NSRC; i++)
    begin : g_src
      logic [1:0] code;
      logic live;
      assign code = levels[2*i+1:2*i];
      assign vecnum[i] = `IPVB_VEC_FIRST + 7'(i);
      assign live = irq_src_in[i] & (code != ipvb_pkg::IPVB_LVL_OFF);
      always_comb
      begin
        if (!live)
          rank[i] = 3'h0;
        else if ({1'b0, fast0_q[5:0]} == vecnum[i])
          rank[i] = `IPVB_RANK_FAST0;
        else if ({1'b0, fast1_q[5:0]} == vecnum[i])
          rank[i] = `IPVB_RANK_FAST1;
        else
          rank[i] = {1'b0, code};
      end
    end
  endgenerate

  // pick the highest rank; scanning downward with >= lets the
  // lower vector number take ties
  always_comb
  begin
    best_rank = 3'h0;
    best_vec = 7'h00;
    for (int j = NSRC - 1; j >= 0; j--)
    begin
      if (rank[j] != 3'h0 && rank[j] >= best_rank)
      begin
        best_rank = rank[j];
        best_vec = vecnum[j];
      end
    end
    any = (best_rank != 3'h0);
    // fast ranks are level 2 by construction; no code maps above 2
    if (best_rank >= 3'h3)
      best_level = 2'h2;
    else if (best_rank == 3'h0)
      best_level = 2'h0;
    else
      best_level = 2'(best_rank - 3'h1);
  end

  // core outputs registered: base on top, winner below
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      req_q <= 1'b0;
      level_q <= 2'h0;
      vab_q <= 21'h00_0000;
    end
    else
    begin
      req_q <= any;
      level_q <= best_level;
      vab_q <= {vbase_q[13:0], best_vec};
    end
  end

  // events: a request appears, or the winner changes under it
  assign events[`IPVB_EV_RAISE] = any & ~req_q;
  assign events[`IPVB_EV_CHANGE] = any & req_q & (best_vec != vab_q[6:0]);

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      status_q <= 2'h0;
      mask_q <= 2'h0;
    end
    else
    begin
      if (wr && idx == `IPVB_IDX_STATUS && wb_sel_in[0])
        status_q <= (status_q & ~wb_dat_in[1:0]) | events;
      else
        status_q <= status_q | events;
      if (wr && idx == `IPVB_IDX_MASK && wb_sel_in[0])
        mask_q <= wb_dat_in[1:0];
    end
  end

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      irq_q <= 1'b0;
    else
      irq_q <= |(status_q & mask_q);
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;
  assign core_req_out = req_q;
  assign core_level_out = level_q;
  assign vector_address_bus_out = vab_q;
  assign irq_out = irq_q;

  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  logic seen_q;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      seen_q <= 1'b0;
    else
      seen_q <= 1'b1;
  end

  a_reset_levels: assert property (
    !seen_q |-> (levels == '0))
    else $error("level fields not zero after reset");
  a_reset_base: assert property (
    !seen_q |-> (vbase_q == VBASE_RESET))
    else $error("vector base reset value wrong");
  a_off_no_req: assert property (
    (levels == '0) |=> !core_req_out)
    else $error("request raised with all sources disabled");
  a_serial_write: assert property (
    (wr && idx == `IPVB_IDX_SERIAL && wb_sel_in[0])
      |=> serial_q[7:0] == $past(wb_dat_in[7:0]))
    else $error("serial level write lost");
  a_timer_write: assert property (
    (wr && idx == `IPVB_IDX_TIMER && wb_sel_in[1])
      |=> timer_q[15:8] == $past(wb_dat_in[15:8]) && timer_q[7:0] == 8'h00)
    else $error("timer level write wrong");
  a_pwm_write: assert property (
    (wr && idx == `IPVB_IDX_PWM && wb_sel_in[1])
      |=> pwm_q[15:8] == {4'h0, $past(wb_dat_in[11:8])})
    else $error("pwm level write wrong");
  a_vab_upper: assert property (
    (seen_q && $stable(vbase_q)) [*2] |-> vab_q[20:7] == vbase_q[13:0])
    else $error("vector base not on upper address bits");
  a_vab_lower: assert property (
    core_req_out |-> vab_q[6:0] >= `IPVB_VEC_FIRST &&
      vab_q[6:0] < `IPVB_VEC_FIRST + 7'(NSRC))
    else $error("vector number out of range");
  a_fast0_wins: assert property (
    (any && best_rank == `IPVB_RANK_FAST0)
      |=> core_req_out && vab_q[6:0] == {1'b0, $past(fast0_q[5:0])})
    else $error("fast interrupt 0 not served first");
  a_fast_level: assert property (
    (best_rank == `IPVB_RANK_FAST1) |=> core_level_out == 2'h2)
    else $error("fast interrupt not at level 2");
  a_irq_follows: assert property (
    (|(status_q & mask_q)) |=> irq_out)
    else $error("interrupt output missed a masked-in status bit");

  c_request: cover property (!core_req_out ##1 core_req_out);
  c_fast: cover property (best_rank == `IPVB_RANK_FAST0);
  c_irq: cover property ($rose(irq_out));

endmodule : ipvb_top

/* tb/ipvb_core_model.sv */
`timescale 1ns/1ps
module ipvb_core_model
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // request from the block
  input wire logic req_in,
  input wire logic [1:0] level_in,
  input wire logic [20:0] vab_in,
  // what the core took
  output logic taken_req_out,
  output logic [1:0] taken_level_out,
  output logic [20:0] taken_vab_out
);
  // core samples every edge; the vector is fetched only under a request
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      taken_req_out <= 1'b0;
      taken_level_out <= 2'h0;
      taken_vab_out <= 21'h000000;
    end
    else
    begin
      taken_req_out <= req_in;
      taken_level_out <= level_in;
      taken_vab_out <= req_in ? vab_in : 21'h000000;
    end
  end
endmodule : ipvb_core_model

/* tb/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
  // bench signals
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wb_cyc_in = 1'b0;
  logic wb_stb_in = 1'b0;
  logic wb_we_in = 1'b0;
  logic [3:0] wb_sel_in = 4'h0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [31:0] wb_dat_in = 32'h00000000;
  logic [13:0] irq_src_in = 14'h0000;
  logic [31:0] wb_dat_out;
  logic wb_ack_out;
  logic core_req_out;
  logic irq_out;
  logic [1:0] core_level_out;
  logic [20:0] vector_address_bus_out;
  logic tk_req;
  logic [1:0] tk_lvl;
  logic [20:0] tk_vab;
  logic [20:0] small_vab;
  logic [15:0] v;
  int n_fail = 0;
  int cmp_count = 0;
  int i;
  int c;

  ipvb_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .irq_src_in(irq_src_in),
    .core_req_out(core_req_out), .core_level_out(core_level_out),
    .vector_address_bus_out(vector_address_bus_out), .irq_out(irq_out));

  ipvb_core_model core (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .req_in(core_req_out), .level_in(core_level_out),
    .vab_in(vector_address_bus_out), .taken_req_out(tk_req),
    .taken_level_out(tk_lvl), .taken_vab_out(tk_vab));

  // small variant on the same bus; only its vector bus is watched
  ipvb_top #(.SMALL_VARIANT(1'b1)) dut_small (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
    .wb_dat_in(wb_dat_in), .wb_dat_out(), .wb_ack_out(),
    .irq_src_in(irq_src_in), .core_req_out(), .core_level_out(),
    .vector_address_bus_out(small_vab), .irq_out());

  // free-running system clock
  initial
  begin
    forever #10 clk_in = ~clk_in;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // one classic cycle; request held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [5:0] idx,
    input logic [15:0] wd, output logic [15:0] rdo);
    int n;
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_sel_in <= 4'h3;
    wb_adr_in <= {idx, 2'b00};
    wb_dat_in <= {16'h0000, wd};
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_in);
      if (wb_ack_out === 1'b1)
        break;
    end
    rdo = wb_dat_out[15:0];
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_sel_in <= 4'h0;
    if (n == 20)
    begin
      n_fail++;
      stop_test();
    end
  endtask : wb_xfer

  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    logic [15:0] x;
    wb_xfer(1'b1, idx, d, x);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [5:0] idx,
    input logic [15:0] ex);
    logic [15:0] x;
    wb_xfer(1'b0, idx, 16'h0000, x);
    `CHK(nm, ex, x)
  endtask : rd_chk

  // lets config and sources reach the core through its one-edge lag
  task automatic settle();
    repeat (3) @(posedge clk_in);
  endtask : settle

  // winner seen by the core: level and whole vector address, base 0x1234 above the winner
  task automatic win_chk(input logic [1:0] lv, input logic [6:0] vn);
    settle();
    `CHK("level", lv, tk_lvl)
    `CHK("vab", {14'h1234, vn}, tk_vab)
  endtask : win_chk

  // register index and field position of source i
  function automatic logic [5:0] reg_of(input int s);
    return (s < 4) ? 6'h04 : (s < 8) ? 6'h05 : 6'h06;
  endfunction : reg_of

  function automatic int sh_of(input int s);
    return (s < 4) ? 2 * s : (s < 8) ? 2 * s : 2 * (s - 8);
  endfunction : sh_of

  // main sequence
  initial
  begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd_chk("serial", 6'h04, 16'h0000);
    rd_chk("timer", 6'h05, 16'h0000);
    rd_chk("pwm", 6'h06, 16'h0000);
    rd_chk("vbase", 6'h07, 16'h0080);
    rd_chk("fast0", 6'h08, 16'h0000);
    `CHK("vab reset", 21'h004000, vector_address_bus_out)
    `CHK("vab small", 21'h000000, small_vab)
    // every field set; software keeps reserved bits at zero
    wr(6'h04, 16'h00FF);
    wr(6'h05, 16'hFF00);
    wr(6'h06, 16'h0FFF);
    wr(6'h07, 16'h3FFF);
    rd_chk("serial", 6'h04, 16'h00FF);
    rd_chk("timer", 6'h05, 16'hFF00);
    rd_chk("pwm", 6'h06, 16'h0FFF);
    rd_chk("vbase", 6'h07, 16'h3FFF);
    rd_chk("unmapped", 6'h3F, 16'h0000);
    for (i = 4; i < 7; i++)
      wr(6'(i), 16'h0000);
    wr(6'h07, 16'h1234);
    // every source alone at every level code
    for (i = 0; i < 14; i++)
    begin
      for (c = 0; c < 4; c++)
      begin
        wr(reg_of(i), 16'(c) << sh_of(i));
        irq_src_in <= 14'(1) << i;
        settle();
        `CHK("req", 1'(c != 0), tk_req)
        if (c != 0)
          win_chk(2'(c - 1), 7'(32 + i));
        irq_src_in <= 14'h0000;
      end
    end
    // higher level wins, then tie to lower vector, then fast ranks
    wr(6'h05, 16'hC200);
    irq_src_in <= 14'h0090;
    win_chk(2'h2, 7'h27);
    wr(6'h05, 16'hC300);
    win_chk(2'h2, 7'h24);
    wr(6'h0B, 16'h0027);
    win_chk(2'h2, 7'h27);
    wr(6'h08, 16'h0024);
    win_chk(2'h2, 7'h24);
    irq_src_in <= 14'h0000;
    wr(6'h08, 16'h0000);
    wr(6'h0B, 16'h0000);
    // status sticks while masked, irq follows mask, one-write clears
    wr(6'h10, 16'h0003);
    wr(6'h11, 16'h0000);
    wr(6'h06, 16'h0001);
    irq_src_in <= 14'h0100;
    settle();
    wb_xfer(1'b0, 6'h10, 16'h0000, v);
    `CHK("raise", 1'b1, v[0])
    `CHK("irq masked", 1'b0, irq_out)
    rd_chk("winner", 6'h12, 16'h8028);
    wr(6'h11, 16'h0001);
    settle();
    `CHK("irq", 1'b1, irq_out)
    wr(6'h10, 16'h0003);
    settle();
    `CHK("irq clear", 1'b0, irq_out)
    // higher level source arriving under a request: winner change
    wr(6'h06, 16'h000D);
    irq_src_in <= 14'h0300;
    settle();
    rd_chk("change", 6'h10, 16'h0002);
    win_chk(2'h2, 7'h29);
    irq_src_in <= 14'h0000;
    stop_test();
  end
endmodule : tb_top
